// ===== logic/sil_elig_dec.sv
// Purpose: Decides whether an opcode word may be repeated in loop mode
// Assumes: Word is a complete one-word instruction
// Notes:   Purely combinational
module sil_elig_dec (
   input  wire logic [15:0] word,
   output logic             elig
);

   logic [3:0] op;
   logic [2:0] mode;
   logic [2:0] opm;
   logic [1:0] sz;

   assign op   = word[15:12];
   assign mode = word[5:3];
   assign opm  = word[8:6];
   assign sz   = word[7:6];

   always_comb begin
      elig = 1'b0;
      if (op == 4'h1 || op == 4'h2 || op == 4'h3) begin
         // Moves: memory or register source, memory destination
         elig = sil_pkg::mem_ind(word[8:6]) &&
                (sil_pkg::mem_ind(mode) || mode == 3'h0 ||
                 mode == sil_pkg::SIL_MODE_AREG);
      end else if (op == 4'h8 || op == 4'h9 || op == 4'hB ||
                   op == 4'hC || op == 4'hD) begin
         if (sil_pkg::mem_ind(mode)) begin
            // Memory to Dx, memory to Ax, Dx to memory
            elig = 1'b1;
            if ((op == 4'h8 || op == 4'hC) && opm[1:0] == 2'h3) begin
               elig = 1'b0;
            end
         end else if (mode == sil_pkg::SIL_MODE_AREG && word[8] &&
                      sz != 2'h3) begin
            // Memory-to-memory extend, decimal and compare forms
            elig = (op == 4'h9 || op == 4'hB || op == 4'hD) ||
                   sz == 2'h0;
         end
      end else if (op == 4'h4 && sil_pkg::mem_ind(mode)) begin
         if (word[11:8] == 4'h0 || word[11:8] == 4'h2 ||
             word[11:8] == 4'h4 || word[11:8] == 4'h6 ||
             word[11:8] == 4'hA) begin
            elig = sz != 2'h3;
         end else if (word[11:6] == 6'h20) begin
            elig = 1'b1;
         end
      end else if (op == 4'hE && word[11] == 1'b0 && sz == 2'h3) begin
         // Memory shifts and rotates move exactly one bit position
         elig = sil_pkg::mem_ind(mode);
      end
      // Only these one-word memory encodings qualify
      elig = elig && (sil_pkg::mem_ind(mode) ||
                      sil_pkg::mem_ind(word[8:6]) ||
                      mode == sil_pkg::SIL_MODE_AREG);
   end

endmodule // sil_elig_dec

// ===== logic/sil_loop_ctrl.sv
// Purpose: Single-instruction loop mode control of the instruction front end
// Assumes: One clock; execution unit reports each completed instruction
// Notes:   All outputs registered; no software-visible registers

// Overview of operation
// - In loop mode replay held pair, no instruction fetches reach the bus.
// - Branch decrements count low word; minus one stores, falls through.
// - Otherwise a true condition discards the count and falls through.
// - Count not expired, condition false: add displacement to PC, branch.
// - Decode register holds looped word; queue holds both branch words.
// - Auto entry on taken branch, displacement minus four, eligible word.
// - Loop word fetched twice; second fetch of it enters loop mode.
// - Interrupt, trace, reset or bus error also leave loop mode.
// - Interrupts accepted only after the branch in loop mode; that exits.
// - Trace enabled traps after each instruction and prevents loop entry, except on resume.
// - Reset aborts everything and clears loop state.
// - Bus error exits; resume from exception reenters without refetch.
// - Only one-word indirect, postincrement, predecrement forms qualify.
// - Byte, word, long moves with listed source, destination modes.
// - Listed arithmetic, logic and compare forms qualify in all sizes; decimal forms in byte size only.
// - Single-operand clear, negate, invert, test, decimal negate qualify.
// - Word memory shifts and rotates by exactly one qualify.
module sil_loop_ctrl (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire sil_pkg::sil_exec_t ex,
   input  wire logic               irq_pend,
   input  wire logic               trace_en,
   input  wire logic               bus_err,
   input  wire logic               rte_resume,
   input  wire logic               fetch_want,
   input  wire logic               fetch_ack,
   input  wire logic [15:0]        fetch_word,
   output logic                    fetch_req_q,
   output logic                    loop_active_q,
   output sil_pkg::sil_res_t       res_q,
   output logic [15:0]             dreg_q,
   output logic [15:0]             q0_q,
   output logic [15:0]             q1_q
);

   sil_pkg::sil_state_t state_q;
   sil_pkg::sil_state_t state_d;
   sil_pkg::sil_res_t   res_d;
   logic [15:0]         last_q;
   logic [15:0]         last_d;
   logic [15:0]         lw_q;
   logic [15:0]         lw_d;
   logic [15:0]         bw_q;
   logic [15:0]         bw_d;
   logic [15:0]         dw_q;
   logic [15:0]         dw_d;
   logic                fetch_req_d;
   logic                loop_active_d;
   logic [15:0]         dreg_d;
   logic [15:0]         q0_d;
   logic [15:0]         q1_d;
   logic                last_elig;
   logic                fetch_elig;
   logic                br;
   logic [15:0]         dec;
   logic                expired;
   logic                cond;
   logic                loop_ok;

   sil_elig_dec u_elig_last (
      .word (last_q),
      .elig (last_elig)
   );

   sil_elig_dec u_elig_fetch (
      .word (fetch_word),
      .elig (fetch_elig)
   );

   assign br      = ex.done && ex.branch;
   assign dec     = ex.cnt - sil_pkg::SIL_CNT_ONE;
   assign expired = dec == sil_pkg::SIL_CNT_EXPIRED;
   assign cond    = sil_pkg::cond_true(ex.word[11:8], ex.ccr);
   // Taken branch back onto the single preceding eligible word
   assign loop_ok = br && !expired && !cond &&
                    ex.disp == sil_pkg::SIL_DISP_LOOP &&
                    last_elig && !trace_en;

   always_comb begin
      state_d = state_q;
      res_d   = '0;
      last_d  = last_q;
      lw_d    = lw_q;
      bw_d    = bw_q;
      dw_d    = dw_q;
      res_d.cnt = ex.cnt;
      res_d.pc  = ex.pc;
      if (ex.done && !ex.branch) begin
         last_d = ex.word;
      end
      if (br) begin
         res_d.cnt = dec;
         if (expired) begin
            res_d.cnt_wr   = 1'b1;
            res_d.seq_next = 1'b1;
         end else if (cond) begin
            res_d.seq_next = 1'b1;
         end else begin
            res_d.cnt_wr  = 1'b1;
            res_d.pc_load = 1'b1;
            res_d.pc      = sil_pkg::branch_target(ex.pc, ex.disp);
         end
      end
      // Inside the loop interrupts wait for the branch
      res_d.irq_take = ex.done && irq_pend &&
                       (state_q != sil_pkg::SIL_LOOP || ex.branch);
      res_d.trace_take = ex.done && trace_en;
      case (state_q)
         sil_pkg::SIL_IDLE,
         sil_pkg::SIL_BERR: begin
            if (loop_ok && !irq_pend) begin
               state_d = sil_pkg::SIL_ARM;
               lw_d    = last_q;
               bw_d    = ex.word;
               dw_d    = ex.disp;
            end else if (state_q == sil_pkg::SIL_BERR && rte_resume) begin
               // Held words survived the handler; no refetch needed
               state_d = sil_pkg::SIL_LOOP;
            end else if (br) begin
               state_d = sil_pkg::SIL_IDLE;
            end
         end
         sil_pkg::SIL_ARM: begin
            if (fetch_ack && fetch_word == lw_q && fetch_elig &&
                !trace_en) begin
               state_d = sil_pkg::SIL_LOOP;
            end else if ((br && !loop_ok) || trace_en ||
                         (ex.done && !ex.branch && ex.word != lw_q)) begin
               state_d = sil_pkg::SIL_IDLE;
            end
         end
         default: begin
            if (bus_err) begin
               state_d = sil_pkg::SIL_BERR;
            end else if ((br && (expired || cond)) ||
                         res_d.irq_take || res_d.trace_take) begin
               state_d = sil_pkg::SIL_IDLE;
            end
         end
      endcase
      if (bus_err && state_d != sil_pkg::SIL_BERR) begin
         state_d = sil_pkg::SIL_IDLE;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= sil_pkg::SIL_IDLE;
         res_q   <= '0;
         last_q  <= sil_pkg::SIL_WORD_RST;
         lw_q    <= sil_pkg::SIL_WORD_RST;
         bw_q    <= sil_pkg::SIL_WORD_RST;
         dw_q    <= sil_pkg::SIL_WORD_RST;
      end else begin
         state_q <= state_d;
         res_q   <= res_d;
         last_q  <= last_d;
         lw_q    <= lw_d;
         bw_q    <= bw_d;
         dw_q    <= dw_d;
      end
   end

   // Decode register and two-word prefetch queue
   always_comb begin
      loop_active_d = state_d == sil_pkg::SIL_LOOP;
      fetch_req_d   = fetch_want && !loop_active_d;
      dreg_d = dreg_q;
      q0_d   = q0_q;
      q1_d   = q1_q;
      if (loop_active_d) begin
         dreg_d = lw_d;
         q0_d   = bw_d;
         q1_d   = dw_d;
      end else if (fetch_ack) begin
         dreg_d = q0_q;
         q0_d   = q1_q;
         q1_d   = fetch_word;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         loop_active_q <= 1'b0;
         fetch_req_q   <= 1'b0;
         dreg_q        <= sil_pkg::SIL_WORD_RST;
         q0_q          <= sil_pkg::SIL_WORD_RST;
         q1_q          <= sil_pkg::SIL_WORD_RST;
      end else begin
         loop_active_q <= loop_active_d;
         fetch_req_q   <= fetch_req_d;
         dreg_q        <= dreg_d;
         q0_q          <= q0_d;
         q1_q          <= q1_d;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   chk_no_loop_fetch: assert property (
      loop_active_q |-> !fetch_req_q)
      else $error("Instruction fetch requested in loop mode");

   chk_count_expire: assert property (
      br && ex.cnt == 16'h0000 |=>
         res_q.cnt_wr && res_q.cnt == 16'hFFFF && res_q.seq_next &&
         !res_q.pc_load)
      else $error("Expired count not stored with fall through");

   chk_cond_fall: assert property (
      br && ex.cnt != 16'h0000 &&
      sil_pkg::cond_true(ex.word[11:8], ex.ccr) |=>
         res_q.seq_next && !res_q.cnt_wr && !res_q.pc_load)
      else $error("True condition did not discard the count");

   chk_branch_take: assert property (
      br && ex.cnt != 16'h0000 &&
      !sil_pkg::cond_true(ex.word[11:8], ex.ccr) |=>
         res_q.pc_load && res_q.cnt == $past(ex.cnt) - 16'h0001 &&
         res_q.pc == $past(ex.pc) + 32'h0000_0002 +
                    {{16{$past(ex.disp[15])}}, $past(ex.disp)})
      else $error("Taken branch target or count wrong");

   chk_queue_hold: assert property (
      loop_active_q ##1 loop_active_q |->
         $stable(dreg_q) && $stable(q0_q) && $stable(q1_q))
      else $error("Held loop words changed in loop mode");

   chk_entry_fetch: assert property (
      $rose(loop_active_q) |-> $past(fetch_ack) || $past(rte_resume))
      else $error("Loop entered without second fetch or resume");

   chk_irq_branch: assert property (
      loop_active_q && ex.done && !ex.branch |=> !res_q.irq_take)
      else $error("Interrupt taken after the looped instruction");

   chk_trace_exit: assert property (
      loop_active_q && ex.done && trace_en |=>
         !loop_active_q && res_q.trace_take)
      else $error("Trace did not end loop mode");

   chk_berr_exit: assert property (
      loop_active_q && bus_err |=> !loop_active_q ##1 !loop_active_q)
      else $error("Bus error did not leave loop mode");

   chk_expire_exit: assert property (
      loop_active_q && br && ex.cnt == 16'h0000 && !bus_err |=>
         !loop_active_q)
      else $error("Expired count did not leave loop mode");

   // Resume and a matching fetch are the only other ways in
   chk_entry_disp: assert property (
      br && ex.disp != sil_pkg::SIL_DISP_LOOP && !loop_active_q &&
      !fetch_ack && !rte_resume |=> !loop_active_q)
      else $error("Loop entered on a branch that is not minus four");

   chk_loop_load: assert property (
      $rose(loop_active_q) |->
         dreg_q == lw_q && q0_q == bw_q && q1_q == dw_q)
      else $error("Loop words not loaded on entry");

   chk_irq_exit: assert property (
      loop_active_q && br && irq_pend && !bus_err |=>
         res_q.irq_take && !loop_active_q)
      else $error("Interrupt after the branch did not end loop mode");

   chk_trace_block: assert property (
      trace_en && !loop_active_q && !rte_resume |=> !loop_active_q)
      else $error("Loop mode entered while tracing");

   chk_reset_clear: assert property (
      $past(rst) |-> !loop_active_q && !fetch_req_q && res_q == '0)
      else $error("Loop state not cleared by reset");

   chk_berr_resume: assert property (
      state_q == sil_pkg::SIL_BERR && rte_resume && !ex.done |=>
         loop_active_q && dreg_q == $past(lw_q))
      else $error("Resume did not restore loop without refetch");

   // Prefetch may only be held off by the loop flag
   chk_fetch_gate: assert property (
      fetch_want |=> fetch_req_q || loop_active_q)
      else $error("Prefetch request gated outside loop mode");

endmodule // sil_loop_ctrl

// ===== logic/sil_pkg.sv
// Purpose: Shared constants, types and helpers of the single-instruction
//          loop controller
// Assumes: 16-bit instruction words, 32-bit program counter
// Notes:   Condition codes are packed as {X,N,Z,V,C}
package sil_pkg;

   localparam logic [15:0] SIL_DISP_LOOP   = 16'hFFFC;
   localparam logic [15:0] SIL_CNT_EXPIRED = 16'hFFFF;
   localparam logic [15:0] SIL_CNT_ONE     = 16'h0001;
   localparam logic [31:0] SIL_PC_STEP     = 32'h0000_0002;
   localparam logic [15:0] SIL_WORD_RST    = 16'h0000;
   localparam logic [31:0] SIL_PC_RST      = 32'h0000_0000;
   localparam logic [2:0]  SIL_MODE_IND    = 3'h2;
   localparam logic [2:0]  SIL_MODE_POST   = 3'h3;
   localparam logic [2:0]  SIL_MODE_PRE    = 3'h4;
   localparam logic [2:0]  SIL_MODE_AREG   = 3'h1;
   localparam int          SIL_CC_C        = 0;
   localparam int          SIL_CC_V        = 1;
   localparam int          SIL_CC_Z        = 2;
   localparam int          SIL_CC_N        = 3;

   typedef enum logic [1:0] {
      SIL_IDLE,
      SIL_ARM,
      SIL_LOOP,
      SIL_BERR
   } sil_state_t;

   // One completed instruction as reported by the execution unit
   typedef struct packed {
      logic        done;
      logic        branch;
      logic [15:0] word;
      logic [15:0] cnt;
      logic [4:0]  ccr;
      logic [15:0] disp;
      logic [31:0] pc;
   } sil_exec_t;

   typedef struct packed {
      logic        cnt_wr;
      logic [15:0] cnt;
      logic        pc_load;
      logic [31:0] pc;
      logic        seq_next;
      logic        irq_take;
      logic        trace_take;
   } sil_res_t;

   function automatic logic mem_ind(input logic [2:0] mode);
      return (mode == SIL_MODE_IND) || (mode == SIL_MODE_POST) ||
             (mode == SIL_MODE_PRE);
   endfunction

   function automatic logic cond_true(input logic [3:0] cc,
                                      input logic [4:0] ccr);
      logic c;
      logic v;
      logic z;
      logic n;
      logic r;
      c = ccr[SIL_CC_C];
      v = ccr[SIL_CC_V];
      z = ccr[SIL_CC_Z];
      n = ccr[SIL_CC_N];
      case (cc[3:1])
         3'h0:    r = 1'b1;
         3'h1:    r = ~c & ~z;
         3'h2:    r = ~c;
         3'h3:    r = ~z;
         3'h4:    r = ~v;
         3'h5:    r = ~n;
         3'h6:    r = ~(n ^ v);
         default: r = ~z & ~(n ^ v);
      endcase
      // Odd codes are the complement of the even ones
      return cc[0] ? ~r : r;
   endfunction

   function automatic logic [31:0] branch_target(input logic [31:0] pc,
                                                 input logic [15:0] disp);
      return pc + SIL_PC_STEP + {{16{disp[15]}}, disp};
   endfunction

endpackage

// ===== testbench/sil_fetch_mem.sv
// Purpose: Memory model answering instruction prefetches of the loop block
// Assumes: Holds the loop program: branch opcode, displacement, loop word
// Notes:   Filler words follow the program; wait_cyc slows each answer
module sil_fetch_mem (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        fetch_req,
   input  wire logic        restart,
   input  wire logic [2:0]  wait_cyc,
   input  wire logic [15:0] loop_word,
   output logic             fetch_ack,
   output logic [15:0]      fetch_word
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] FILLER = 16'h4E71;
   logic [1:0]  ptr;
   logic [2:0]  cnt;
   logic [15:0] nxt;
   always_comb begin
      case (ptr)
         2'h0:    nxt = 16'h51C8;
         2'h1:    nxt = 16'hFFFC;
         2'h2:    nxt = loop_word;
         default: nxt = FILLER;
      endcase
   end
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ptr        <= 2'h0;
         cnt        <= 3'h0;
         fetch_ack  <= 1'b0;
         fetch_word <= 16'h0000;
      end else begin
         fetch_ack  <= 1'b0;
         // Outside an answer the data lines invert their last value every cycle
         fetch_word <= ~fetch_word;
         if (fetch_req && !fetch_ack) begin
            if (cnt < wait_cyc) begin
               cnt <= cnt + 3'h1;
            end else begin
               cnt        <= 3'h0;
               fetch_ack  <= 1'b1;
               fetch_word <= nxt;
               if (ptr != 2'h3) ptr <= ptr + 2'h1;
            end
         end
         if (restart) ptr <= 2'h0;
      end
   end
endmodule // sil_fetch_mem

// ===== testbench/single_instruction_loop_mode_bench.sv
// Purpose: Self-checking bench of the single-instruction loop controller
// Assumes: Execution reports driven by the bench, prefetches by a model
// Notes:   Loop program lives at PC 0100 with displacement minus four
module single_instruction_loop_mode_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] BR_NEVER = 16'h51C8;
   localparam logic [15:0] BR_ALWAYS = 16'h50C8;
   localparam logic [15:0] BR_EQ = 16'h57C8;
   localparam logic [15:0] W_MOVE = 16'h32D8;
   localparam logic [31:0] PC = 32'h0000_0100;
   logic               ref_clk, rst, irq_pend, trace_en, bus_err, rte_resume;
   logic               fetch_want, fetch_ack, restart, fetch_req_q;
   logic               loop_active_q;
   logic [15:0]        fetch_word, dreg_q, q0_q, q1_q, lw;
   logic [2:0]         mem_wait;
   sil_pkg::sil_exec_t ex;
   sil_pkg::sil_res_t  res_q;
   int                 err_count, tests_run;
   logic [15:0] el_word [10] = '{16'h32D8, 16'h3290, 16'hD150, 16'hD058,
      16'hB150, 16'h4290, 16'h4A58, 16'hE1D0, 16'h3200, 16'hE148};
   logic el_ok [10] = '{1, 1, 1, 1, 1, 1, 1, 1, 0, 0};

   sil_loop_ctrl i_sil_loop_ctrl (.ref_clk(ref_clk), .rst(rst), .ex(ex),
      .irq_pend(irq_pend), .trace_en(trace_en), .bus_err(bus_err),
      .rte_resume(rte_resume), .fetch_want(fetch_want),
      .fetch_ack(fetch_ack), .fetch_word(fetch_word),
      .fetch_req_q(fetch_req_q), .loop_active_q(loop_active_q),
      .res_q(res_q), .dreg_q(dreg_q), .q0_q(q0_q), .q1_q(q1_q));
   sil_fetch_mem i_sil_fetch_mem (.ref_clk(ref_clk), .rst(rst),
      .fetch_req(fetch_req_q), .restart(restart), .wait_cyc(mem_wait),
      .loop_word(lw), .fetch_ack(fetch_ack), .fetch_word(fetch_word));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic summarize;
      $display("Checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Leaves the bench just after the edge that took the report
   task automatic do_done(input logic br, input logic [15:0] w, c, d,
                          input logic [4:0] ccr);
      @(posedge ref_clk);
      ex <= '{done: 1'b1, branch: br, word: w, cnt: c, ccr: ccr, disp: d,
              pc: PC};
      @(posedge ref_clk);
      ex.done <= 1'b0;
      #1;
   endtask

   task automatic arm(input logic [15:0] w, br_op, c);
      lw = w;
      do_done(1'b0, w, 16'h0000, 16'h0000, 5'h00);
      do_done(1'b1, br_op, c, sil_pkg::SIL_DISP_LOOP, 5'h00);
      @(posedge ref_clk);
      restart <= 1'b1;
      @(posedge ref_clk);
      restart <= 1'b0;
   endtask

   task automatic wait_entry(input logic exp);
      for (int n = 0; n < 30; n++) begin
         @(posedge ref_clk);
         if (loop_active_q === 1'b1) break;
      end
      #1;
      chk("loop_active_q", exp, loop_active_q);
      if (exp && loop_active_q !== 1'b1) summarize();
   endtask

   task automatic enter(input logic [15:0] w);
      arm(w, BR_NEVER, 16'h0005);
      wait_entry(1'b1);
   endtask

   task automatic exit_expire;
      do_done(1'b1, BR_NEVER, 16'h0000, sil_pkg::SIL_DISP_LOOP, 5'h00);
      @(posedge ref_clk);
      #1;
      chk("loop_active_q", 0, loop_active_q);
   endtask

   task automatic t_results;
      do_done(1'b1, BR_EQ, 16'h0005, 16'h0010, 5'h00);
      chk("pc_load", 1, res_q.pc_load);
      chk("pc", PC + sil_pkg::SIL_PC_STEP + 32'h0000_0010, res_q.pc);
      chk("cnt", 16'h0004, res_q.cnt);
      do_done(1'b1, BR_EQ, 16'h0005, 16'h0010, 5'h04);
      chk("seq_next", 1, res_q.seq_next);
      chk("cnt_wr", 0, res_q.cnt_wr);
      chk("pc_load", 0, res_q.pc_load);
      do_done(1'b1, BR_EQ, 16'h0000, 16'h0010, 5'h04);
      chk("cnt_wr", 1, res_q.cnt_wr);
      chk("cnt", sil_pkg::SIL_CNT_EXPIRED, res_q.cnt);
      chk("seq_next", 1, res_q.seq_next);
      chk("pc_load", 0, res_q.pc_load);
   endtask

   task automatic t_refused;
      arm(W_MOVE, BR_ALWAYS, 16'h0005);
      wait_entry(1'b0);
      arm(W_MOVE, BR_NEVER, 16'h0000);
      wait_entry(1'b0);
   endtask

   task automatic t_loop_body;
      mem_wait <= 3'h3;
      enter(W_MOVE);
      chk("dreg_q", W_MOVE, dreg_q);
      chk("q0_q", BR_NEVER, q0_q);
      chk("q1_q", sil_pkg::SIL_DISP_LOOP, q1_q);
      repeat (8) begin
         @(posedge ref_clk);
         #1;
         chk("fetch_req_q", 0, fetch_req_q);
         chk("fetch_ack", 0, fetch_ack);
      end
      exit_expire();
      mem_wait <= 3'h0;
   endtask

   task automatic t_irq;
      enter(W_MOVE);
      irq_pend <= 1'b1;
      do_done(1'b0, W_MOVE, 16'h0000, 16'h0000, 5'h00);
      chk("irq_take", 0, res_q.irq_take);
      chk("loop_active_q", 1, loop_active_q);
      do_done(1'b1, BR_NEVER, 16'h0005, sil_pkg::SIL_DISP_LOOP, 5'h00);
      chk("irq_take", 1, res_q.irq_take);
      @(posedge ref_clk);
      irq_pend <= 1'b0;
      #1;
      chk("loop_active_q", 0, loop_active_q);
   endtask

   task automatic t_trace;
      enter(W_MOVE);
      trace_en <= 1'b1;
      do_done(1'b0, W_MOVE, 16'h0000, 16'h0000, 5'h00);
      chk("trace_take", 1, res_q.trace_take);
      chk("loop_active_q", 0, loop_active_q);
      @(posedge ref_clk);
      trace_en <= 1'b1;
      arm(W_MOVE, BR_NEVER, 16'h0005);
      chk("trace_take", 0, res_q.trace_take);
      do_done(1'b0, W_MOVE, 16'h0000, 16'h0000, 5'h00);
      chk("trace_take", 1, res_q.trace_take);
      do_done(1'b1, BR_NEVER, 16'h0005, sil_pkg::SIL_DISP_LOOP, 5'h00);
      chk("trace_take", 1, res_q.trace_take);
      wait_entry(1'b0);
      trace_en <= 1'b0;
   endtask

   task automatic t_berr;
      enter(W_MOVE);
      fetch_want <= 1'b0;
      bus_err    <= 1'b1;
      @(posedge ref_clk);
      bus_err <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk("loop_active_q", 0, loop_active_q);
      @(posedge ref_clk);
      rte_resume <= 1'b1;
      @(posedge ref_clk);
      rte_resume <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk("loop_active_q", 1, loop_active_q);
      chk("dreg_q", W_MOVE, dreg_q);
      chk("q0_q", BR_NEVER, q0_q);
      chk("fetch_req_q", 0, fetch_req_q);
      fetch_want <= 1'b1;
      exit_expire();
   endtask

   task automatic t_elig;
      for (int i = 0; i < 10; i++) begin
         arm(el_word[i], BR_NEVER, 16'h0005);
         wait_entry(el_ok[i]);
         if (el_ok[i]) exit_expire();
      end
   endtask

   task automatic t_reset;
      enter(W_MOVE);
      rst <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk("loop_active_q", 0, loop_active_q);
      chk("dreg_q", 0, dreg_q);
      chk("res_q zero", 1, res_q === '0);
      @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   initial begin
      ex = '0;
      rst = 1'b1;
      irq_pend = 1'b0;
      trace_en = 1'b0;
      bus_err = 1'b0;
      rte_resume = 1'b0;
      fetch_want = 1'b1;
      restart = 1'b0;
      mem_wait = 3'h0;
      lw = W_MOVE;
      err_count = 0;
      tests_run = 0;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      t_results();
      t_refused();
      t_loop_body();
      t_irq();
      t_trace();
      t_berr();
      t_elig();
      t_reset();
      enter(W_MOVE);
      summarize();
   end
endmodule // single_instruction_loop_mode_bench
